// >>> eag_config.v
// Notes on behaviour
// (R1) Bit 7 of accumulation mode reports the current input used under tamper.
// (R2) Bit 6 chooses fault event on entering fault or returning normal.
// (R3) Bit 5 chooses reactive sign event direction, clear means positive-to-negative.
// (R4) Bit 4 chooses active sign event direction, clear means positive-to-negative.
// (R5) Bit 3 accumulates absolute reactive power into register and pulse path.
// (R6) Bit 2 negates reactive power while active power is negative.
// (R7) Bit 1 accumulates only positive active power.
// (R8) Bit 0 accumulates absolute active power.
// (R9) Gain bits 7 to 5 set voltage gain 1 to 16.
// (R10) Gain bits 2 to 0 set current gain 1 to 16.
// (R11) Gain bit 3 selects sign detection on filtered power or pulses.
// (R12) Calibration bits 5 to 4 force input A, B or automatic.
// (R13) Calibration bit 3 grounds the voltage input.
// (R14) Calibration bit 2 grounds the current input.
// (R15) Software writes zero to calibration bits 7 to 6 and 1 to 0.
// (R16) Gain codes above 100 are reserved; gain bit 4 reads zero.
// (R17) Status bits 5, 4, 3 set on fault, reactive and active sign events.
// (R18) A set flag raises the interrupt only when its enable is one.
// Purpose: Accumulation, gain and calibration configuration with AXI4-Lite access.
// Assumes: Power samples are signed and arrive with a valid strobe on aclk.
// Notes: Write one to clear status; interrupt is a level.
`timescale 1ns/1ns
`include "eag_defines.vh"
module eag_config (
  input  wire                   aclk,
  input  wire                   aresetn,
  input  wire [`EAG_ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]             s_axi_awprot,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`EAG_ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]             s_axi_arprot,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  input  wire                   power_valid,
  input  wire [`EAG_PW-1:0]     active_power,
  input  wire [`EAG_PW-1:0]     reactive_power,
  input  wire                   energy_pulse_output,
  input  wire                   fault_mode_pin,
  input  wire                   tamper_use_b,
  output reg  [`EAG_PW-1:0]     active_accum_power,
  output reg  [`EAG_PW-1:0]     reactive_accum_power,
  output reg  [4:0]             voltage_gain,
  output reg  [4:0]             current_gain,
  output reg                    current_input_b,
  output reg                    voltage_input_ground,
  output reg                    current_input_ground,
  output wire                   irq
);
  reg  [7:0] accum_r;
  reg  [7:0] gain_r;
  reg  [7:0] cal_r;
  reg  [7:0] status_r;
  reg  [7:0] mask_r;
  reg        aw_held_r;
  reg        w_held_r;
  reg  [`EAG_ADDR_W-1:0] awaddr_r;
  reg  [7:0] wbyte_r;
  reg        fault_prev_r;
  reg  [1:0] settle_r;
  wire       fault_armed;
  wire       fault_s;
  wire       tamper_s;
  wire       a_neg;
  wire       r_neg;
  wire       sign_sample;
  wire       a_evt;
  wire       r_evt;
  wire       f_evt;
  wire       wr_go;
  wire [7:0] wr_idx;
  wire [7:0] rd_idx;
  wire       wr_hit;
  wire       rd_hit;
  reg  [7:0] rd_byte;
  reg  [7:0] set_bits;

  function [4:0] gain_decode;
    input [2:0] code;
    begin
      case (code)
        3'h0:    gain_decode = 5'h01;
        3'h1:    gain_decode = 5'h02;
        3'h2:    gain_decode = 5'h04;
        3'h3:    gain_decode = 5'h08;
        3'h4:    gain_decode = 5'h10;
        default: gain_decode = 5'h01;
      endcase
    end
  endfunction

  function is_mapped;
    input [7:0] idx;
    begin
      is_mapped = (idx == `EAG_IDX_ACCUM) || (idx == `EAG_IDX_GAIN) ||
                  (idx == `EAG_IDX_CAL) || (idx == `EAG_IDX_STATUS) ||
                  (idx == `EAG_IDX_MASK);
    end
  endfunction

  eag_sync u_sync_fault (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (fault_mode_pin),
    .dout    (fault_s)
  );

  eag_sync u_sync_tamper (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (tamper_use_b),
    .dout    (tamper_s)
  );

  assign a_neg = active_power[`EAG_PW-1];
  assign r_neg = reactive_power[`EAG_PW-1];
  // (R11) Sign detect location.
  assign sign_sample = gain_r[`EAG_BIT_SIGNLOC] ? (power_valid & energy_pulse_output)
                                                : power_valid;

  // (R4) Active sign direction.
  eag_sign_det u_det_active (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .sample     (sign_sample),
    .negative   (a_neg),
    .rising_dir (accum_r[`EAG_BIT_ASIGN]),
    .event_p    (a_evt)
  );

  // (R3) Reactive sign direction.
  eag_sign_det u_det_react (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .sample     (sign_sample),
    .negative   (r_neg),
    .rising_dir (accum_r[`EAG_BIT_RSIGN]),
    .event_p    (r_evt)
  );

  // (R2) Settle after reset.
  // A pin held in fault mode through reset must not look like a fresh edge.
  assign fault_armed = (settle_r == `EAG_SETTLE_DONE);
  // (R2) Fault event direction.
  assign f_evt = fault_armed && (fault_s != fault_prev_r) &&
                 (accum_r[`EAG_BIT_FAULTDIR] ? !fault_s : fault_s);

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go  = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_idx = awaddr_r[`EAG_ADDR_W-1:2];
  assign rd_idx = s_axi_araddr[`EAG_ADDR_W-1:2];
  assign wr_hit = is_mapped(wr_idx);
  assign rd_hit = is_mapped(rd_idx);
  // (R18) Masked interrupt.
  assign irq = |(status_r & mask_r);

  always @* begin
    set_bits = `EAG_RST_BYTE;
    // (R17) Event flag setting.
    set_bits[`EAG_ST_FAULT] = f_evt;
    set_bits[`EAG_ST_RSIGN] = r_evt;
    set_bits[`EAG_ST_ASIGN] = a_evt;
  end

  always @* begin
    case (rd_idx)
      // (R1) Tamper input report.
      `EAG_IDX_ACCUM:  rd_byte = {tamper_s, accum_r[`EAG_BIT_FAULTDIR:0]};
      // (R16) Reserved bit reads zero.
      `EAG_IDX_GAIN:   rd_byte = gain_r & ~(8'h01 << `EAG_BIT_GAIN_RSV);
      `EAG_IDX_CAL:    rd_byte = cal_r;
      `EAG_IDX_STATUS: rd_byte = status_r;
      `EAG_IDX_MASK:   rd_byte = mask_r;
      default:         rd_byte = `EAG_RST_BYTE;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= {`EAG_ADDR_W{1'b0}};
      wbyte_r      <= `EAG_RST_BYTE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EAG_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `EAG_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      accum_r      <= `EAG_RST_BYTE;
      gain_r       <= `EAG_RST_BYTE;
      cal_r        <= `EAG_RST_BYTE;
      status_r     <= `EAG_RST_BYTE;
      mask_r       <= `EAG_RST_BYTE;
      fault_prev_r <= 1'b0;
      settle_r     <= `EAG_SETTLE_RST;
    end else begin
      fault_prev_r <= fault_s;
      if (!fault_armed)
        settle_r <= settle_r + `EAG_SETTLE_STEP;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wbyte_r  <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : `EAG_RST_BYTE;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      status_r <= status_r | set_bits;
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `EAG_RESP_OKAY : `EAG_RESP_SLVERR;
        if (w_held_r) begin
          case (wr_idx)
            `EAG_IDX_ACCUM:  accum_r <= wbyte_r;
            // (R16) Reserved gain bit.
            `EAG_IDX_GAIN:   gain_r <= wbyte_r & ~(8'h01 << `EAG_BIT_GAIN_RSV);
            // (R15) Stored as written.
            `EAG_IDX_CAL:    cal_r <= wbyte_r;
            // (R17) Set wins over clear.
            `EAG_IDX_STATUS: status_r <= (status_r & ~wbyte_r) | set_bits;
            `EAG_IDX_MASK:   mask_r <= wbyte_r & `EAG_ST_MASK;
            default:         mask_r <= mask_r;
          endcase
        end
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_hit ? `EAG_RESP_OKAY : `EAG_RESP_SLVERR;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      active_accum_power   <= {`EAG_PW{1'b0}};
      reactive_accum_power <= {`EAG_PW{1'b0}};
      voltage_gain         <= 5'h01;
      current_gain         <= 5'h01;
      current_input_b      <= 1'b0;
      voltage_input_ground <= 1'b0;
      current_input_ground <= 1'b0;
    end else begin
      // (R8) Absolute active.
      if (accum_r[`EAG_BIT_AABS])
        active_accum_power <= a_neg ? (~active_power + 1'b1) : active_power;
      // (R7) Positive-only active.
      else if (accum_r[`EAG_BIT_APOS])
        active_accum_power <= a_neg ? {`EAG_PW{1'b0}} : active_power;
      else
        active_accum_power <= active_power;
      // (R5) Absolute reactive.
      if (accum_r[`EAG_BIT_RABS])
        reactive_accum_power <= r_neg ? (~reactive_power + 1'b1) : reactive_power;
      // (R6) Reactive signed by active.
      else if (accum_r[`EAG_BIT_RSBA])
        reactive_accum_power <= a_neg ? (~reactive_power + 1'b1) : reactive_power;
      else
        reactive_accum_power <= reactive_power;
      // (R9) Voltage gain decode.
      voltage_gain <= gain_decode(gain_r[`EAG_VGAIN_HI:`EAG_VGAIN_LO]);
      // (R10) Current gain decode.
      current_gain <= gain_decode(gain_r[`EAG_IGAIN_HI:`EAG_IGAIN_LO]);
      // (R12) Input selection.
      case (cal_r[`EAG_SEL_HI:`EAG_SEL_LO])
        `EAG_SEL_FORCE_A: current_input_b <= 1'b0;
        `EAG_SEL_FORCE_B: current_input_b <= 1'b1;
        default:          current_input_b <= tamper_s;
      endcase
      // (R13) Voltage ground.
      voltage_input_ground <= cal_r[`EAG_BIT_VGND];
      // (R14) Current ground.
      current_input_ground <= cal_r[`EAG_BIT_IGND];
    end
  end
endmodule

// >>> eag_config_checker.sv
// Purpose: Port checker for the metering configuration block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ns
module eag_config_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [4:0]  voltage_gain,
  input wire [4:0]  current_gain,
  input wire        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_gain_onehot: assert property ($onehot(voltage_gain) && $onehot(current_gain))
    else $error("gain output not one-hot");
  a_reset_clear: assert property (disable iff (1'h0) !aresetn |=>
    voltage_gain == 5'h01 && current_gain == 5'h01 && !irq)
    else $error("reset values wrong");
  c_irq: cover property ($rose(irq));
  c_tamper: cover property (s_axi_rvalid && s_axi_rdata[7]);
  c_gain16: cover property (current_gain == 5'h10);
endmodule

bind eag_config eag_config_checker chk (.*);

// >>> eag_config_test.sv
// Purpose: Self-checking bench for the metering configuration block.
// Assumes: AXI4-Lite master with both ready inputs held high.
// Notes: Random values from a fixed xorshift seed.
`timescale 1ns/1ns
module eag_config_test;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1, power_valid = 0, energy_pulse_output = 0;
  logic fault_mode_pin = 0, tamper_use_b = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h83D2, rv;
  logic [23:0] active_power = 0, reactive_power = 0, active_accum_power, reactive_accum_power;
  logic [4:0] voltage_gain, current_gain;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic current_input_b, voltage_input_ground, current_input_ground;
  int bad_count = 0, compares = 0;
  eag_config uut (.*);
  always #2 aclk = ~aclk;
  function automatic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic [4:0] g(input [2:0] c);
    return (c <= 3'h4) ? 5'h01 << c : 5'h01;
  endfunction
  function automatic [23:0] ab(input [23:0] x);
    return x[23] ? -x : x;
  endfunction
  task complete_run;
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tmo;
    bad_count++;
    complete_run;
  endtask
  task wr(input [9:0] a, input [31:0] d);
    int n;
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_bvalid === 1'h1) break;
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end
    if (n == 50) tmo;
    rr = s_axi_bresp;
  endtask
  task rd(input [9:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'h1) break;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    if (n == 50) tmo;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task cr(input [9:0] a, input [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task samp(input [23:0] p, input [23:0] q);
    active_power <= p;
    reactive_power <= q;
    power_valid <= 1;
    @(posedge aclk);
    power_valid <= 0;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    int k, d;
    logic [31:0] x;
    logic [23:0] e;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    cr(10'h03C, 0);
    cr(10'h06C, 0);
    cr(10'h0F4, 0);
    rd(10'h3F0);
    chk(rv, 0);
    chk(rr, 2'h2);
    wr(10'h3F0, 32'hFF);
    chk(rr, 2'h2);
    for (k = 0; k < 12; k++) begin
      x = rnd() & 32'hFF;
      if (k < 8) x[7:0] = {k[2:0], x[4:3], 3'h7 - k[2:0]};
      wr(10'h06C, x);
      repeat (2) @(posedge aclk);
      chk(voltage_gain, g(x[7:5]));
      chk(current_gain, g(x[2:0]));
      cr(10'h06C, x & 32'hEF);
    end
    for (k = 0; k < 8; k++) begin
      tamper_use_b <= k[2];
      x = {k[1:0], 4'h0} | (rnd() & 32'hC);
      wr(10'h0F4, x);
      repeat (4) @(posedge aclk);
      chk(current_input_b, x[5:4] == 2'h1 ? 0 : x[5:4] == 2'h2 ? 1 : k[2]);
      chk({voltage_input_ground, current_input_ground}, x[3:2]);
      cr(10'h03C, {k[2], 7'h00});
      cr(10'h0F4, x);
    end
    tamper_use_b <= 0;
    for (k = 0; k < 24; k++) begin
      x = k & 15;
      wr(10'h03C, x);
      active_power <= 24'(rnd());
      reactive_power <= 24'(rnd());
      power_valid <= 1;
      repeat (2) @(posedge aclk);
      e = x[0] ? ab(active_power) : (x[1] && active_power[23]) ? 24'h0 : active_power;
      chk(active_accum_power, e);
      e = (x[2] && active_power[23]) ? -reactive_power : reactive_power;
      chk(reactive_accum_power, x[3] ? ab(reactive_power) : e);
      power_valid <= 0;
      cr(10'h03C, x);
    end
    for (k = 0; k < 4; k++) begin
      d = k & 1;
      e = d ? 24'h000100 : 24'hFFFF00;
      energy_pulse_output <= (k == 3);
      wr(10'h03C, {d[0], d[0], 4'h0});
      wr(10'h06C, k >= 2 ? 8 : 0);
      wr(10'h104, k == 0 ? 32'h18 : 32'h0);
      samp(e, e);
      wr(10'h100, 32'h38);
      samp(~e, ~e);
      cr(10'h100, 0);
      samp(e, e);
      cr(10'h100, k != 2 ? 32'h18 : 0);
      chk(irq, k == 0);
      wr(10'h100, 32'h18);
      cr(10'h100, 0);
      chk(irq, 0);
    end
    wr(10'h104, 32'hFF);
    cr(10'h104, 32'h38);
    s_axi_wstrb <= 4'hE;
    wr(10'h104, 32'hFF);
    s_axi_wstrb <= 4'hF;
    cr(10'h104, 0);
    wr(10'h104, 32'hFF);
    for (k = 0; k < 2; k++) begin
      wr(10'h03C, k << 6);
      fault_mode_pin <= k[0];
      repeat (8) @(posedge aclk);
      wr(10'h100, 32'h38);
      fault_mode_pin <= !k[0];
      repeat (8) @(posedge aclk);
      cr(10'h100, 32'h20);
      chk(irq, 1);
      wr(10'h100, 32'h20);
      fault_mode_pin <= k[0];
      repeat (8) @(posedge aclk);
      cr(10'h100, 0);
    end
    aresetn <= 0;
    @(posedge aclk);
    aresetn <= 1;
    cr(10'h03C, 0);
    cr(10'h104, 0);
    cr(10'h100, 0);
    complete_run;
  end
endmodule

// >>> eag_defines.vh
// Purpose: Constants for the metering configuration block.
// Assumes: Byte addresses are four times the printed register index.
// Notes: Definitions only.
`ifndef EAG_DEFINES_VH
`define EAG_DEFINES_VH
`define EAG_IDX_ACCUM        8'h0F
`define EAG_IDX_GAIN         8'h1B
`define EAG_IDX_CAL          8'h3D
`define EAG_IDX_STATUS       8'h40
`define EAG_IDX_MASK         8'h41
`define EAG_ADDR_W           10
`define EAG_RESP_OKAY        2'h0
`define EAG_RESP_SLVERR      2'h2
`define EAG_BIT_ICH          7
`define EAG_BIT_FAULTDIR     6
`define EAG_BIT_RSIGN        5
`define EAG_BIT_ASIGN        4
`define EAG_BIT_RABS         3
`define EAG_BIT_RSBA         2
`define EAG_BIT_APOS         1
`define EAG_BIT_AABS         0
`define EAG_GAIN_MAX         3'h4
`define EAG_VGAIN_HI         7
`define EAG_VGAIN_LO         5
`define EAG_IGAIN_HI         2
`define EAG_IGAIN_LO         0
`define EAG_SEL_HI           5
`define EAG_SEL_LO           4
`define EAG_SETTLE_RST       2'h0
`define EAG_SETTLE_STEP      2'h1
`define EAG_SETTLE_DONE      2'h3
`define EAG_BIT_SIGNLOC      3
`define EAG_BIT_GAIN_RSV     4
`define EAG_BIT_VGND         3
`define EAG_BIT_IGND         2
`define EAG_SEL_FORCE_A      2'h1
`define EAG_SEL_FORCE_B      2'h2
`define EAG_ST_FAULT         5
`define EAG_ST_RSIGN         4
`define EAG_ST_ASIGN         3
`define EAG_ST_MASK          8'h38
`define EAG_RST_BYTE         8'h00
`define EAG_PW               24
`endif

// >>> eag_sign_det.v
// Purpose: Sign change detector with selectable direction.
// Assumes: Samples arrive as a strobe with a sign level.
// Notes: Output is a one-cycle pulse.
`timescale 1ns/1ns
module eag_sign_det (
  input  wire aclk,
  input  wire aresetn,
  input  wire sample,
  input  wire negative,
  input  wire rising_dir,
  output reg  event_p
);
  reg neg_r;
  reg seen_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      neg_r   <= 1'b0;
      seen_r  <= 1'b0;
      event_p <= 1'b0;
    end else begin
      event_p <= 1'b0;
      if (sample) begin
        neg_r  <= negative;
        seen_r <= 1'b1;
        if (seen_r && (neg_r != negative))
          event_p <= rising_dir ? neg_r : negative;
      end
    end
  end
endmodule

// >>> eag_sync.v
// Purpose: Two-flop synchroniser for an asynchronous level.
// Assumes: One clock, synchronous active-low reset.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ns
module eag_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire din,
  output reg  dout
);
  reg meta_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule
